//--- rtl/pwm_time_base_counter.sv
// Purpose: PWM time base counter with control and count registers
// Assumes: APB slave, one wait state, 20 MHz clk is the count clock
// Notes:   Outputs are registered; one wait state on every access
// Summary of operation
// RULE1: Count register bits 14..0 hold readable writable count
// RULE2: Bit 15 direction flag, writes ignored
// RULE3: Direction reads one when counting down
// RULE4: Unimplemented bits read zero, writes ignored
// RULE5: Control holds mode, prescale, postscale, enable
// RULE6: Period register sets count limit
// RULE7: Enable and idle stop control counting; postscale divides period ticks
`default_nettype none
module pwm_time_base_counter
   import time_base_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        idleMode,
   output logic             periodTick
);
   // -------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------
   typedef struct packed {
      logic [15:0] control;
      logic [14:0] count;
      logic        down;
      logic [14:0] period;
      logic [31:0] rdata;
      logic        ready;
      logic        err;
      logic        tick;
   } tb_state_type;

   tb_state_type stateReg;
   tb_state_type stateNext;

   logic       preTick;
   logic       postTick;
   logic       running;
   logic       wrEn;
   logic       rdEn;
   logic       mapped;
   logic       wrap;
   logic [5:0] preLimit;
   logic [5:0] postLimit;
   mode_type   mode;

   assign mode    = mode_type'(stateReg.control[MODE_LSB +: 2]);
   // Halt when disabled, or when idle with idle-stop set
   assign running = stateReg.control[ON_BIT] &&
                    !(idleMode && stateReg.control[IDLE_STOP_BIT]); // [RULE7]
   assign wrEn    = psel && penable && pwrite && !stateReg.ready;
   assign rdEn    = psel && penable && !pwrite && !stateReg.ready;
   assign mapped  = (paddr == CONTROL_ADDR) || (paddr == COUNT_ADDR) ||
                    (paddr == PERIOD_ADDR);

   // -------------------------------------------------------------------
   // Prescaler 1:1, 1:4, 1:16, 1:64
   // -------------------------------------------------------------------
   always_comb begin
      case (stateReg.control[PRE_LSB +: 2]) // [RULE5]
         2'b00:   preLimit = 6'h00;
         2'b01:   preLimit = 6'h03;
         2'b10:   preLimit = 6'h0F;
         2'b11:   preLimit = 6'h3F;
         default: preLimit = 6'h00;
      endcase
   end

   assign postLimit = {2'b00, stateReg.control[POST_LSB +: 4]}; // [RULE7]

   tick_divider preDiv (
      .clk     (clk),
      .nrst    (nrst),
      .clear   (!running),
      .tickIn  (1'b1),
      .limit   (preLimit),
      .tickOut (preTick)
   );

   tick_divider postDiv (
      .clk     (clk),
      .nrst    (nrst),
      .clear   (!running),
      .tickIn  (wrap),
      .limit   (postLimit),
      .tickOut (postTick)
   );

   // -------------------------------------------------------------------
   // Counter and registers
   // -------------------------------------------------------------------
   always_comb begin
      stateNext       = stateReg;
      stateNext.ready = 1'b0;
      stateNext.err   = 1'b0;
      stateNext.tick  = postTick;
      wrap            = 1'b0;
      if (running && preTick) begin
         case (mode)
            MODE_FREE, MODE_SINGLE: begin
               stateNext.down = 1'b0;
               if (stateReg.count >= stateReg.period) begin // [RULE6]
                  wrap            = 1'b1;
                  stateNext.count = COUNT_RESET;
                  // Single event: stop itself after one period
                  if (mode == MODE_SINGLE) begin
                     stateNext.control[ON_BIT] = 1'b0;
                  end
               end else begin
                  stateNext.count = stateReg.count + 15'h0001;
               end
            end
            MODE_UPDOWN, MODE_UPDOWN_DBL: begin
               if (!stateReg.down) begin
                  if (stateReg.count >= stateReg.period) begin // [RULE6]
                     stateNext.down = 1'b1; // [RULE3]
                     if (stateReg.period != 15'h0000) begin
                        stateNext.count = stateReg.count - 15'h0001;
                     end
                     if (mode == MODE_UPDOWN_DBL) begin
                        wrap = 1'b1;
                     end
                  end else begin
                     stateNext.count = stateReg.count + 15'h0001;
                  end
               end else if (stateReg.count <= 15'h0001) begin
                  stateNext.down  = 1'b0; // [RULE3]
                  stateNext.count = COUNT_RESET;
                  wrap            = 1'b1;
               end else begin
                  stateNext.count = stateReg.count - 15'h0001;
               end
            end
            default: stateNext.count = stateReg.count;
         endcase
      end
      // Bus write wins over counting in the same cycle
      if (wrEn) begin
         stateNext.ready = 1'b1;
         stateNext.err   = !mapped;
         case (paddr)
            CONTROL_ADDR: stateNext.control = pwdata[15:0] & CONTROL_MASK;
            // Bit 15 of a count write is dropped
            COUNT_ADDR:   stateNext.count = pwdata[14:0]; // [RULE1] [RULE2]
            PERIOD_ADDR:  stateNext.period = pwdata[14:0]; // [RULE6]
            default:      stateNext.count = stateNext.count;
         endcase
      end
      if (rdEn) begin
         stateNext.ready = 1'b1;
         stateNext.err   = !mapped;
         case (paddr)
            CONTROL_ADDR: stateNext.rdata =
               {16'h0000, stateReg.control & CONTROL_MASK}; // [RULE4] [RULE5]
            COUNT_ADDR:   stateNext.rdata =
               {16'h0000, stateReg.down, stateReg.count}; // [RULE1] [RULE2]
            PERIOD_ADDR:  stateNext.rdata = {17'h00000, stateReg.period};
            default:      stateNext.rdata = 32'h00000000; // [RULE4]
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         stateReg         <= '0;
         stateReg.control <= CONTROL_RESET;
         stateReg.count   <= COUNT_RESET;
         stateReg.period  <= PERIOD_RESET;
      end else begin
         stateReg <= stateNext;
      end
   end

   assign prdata     = stateReg.rdata;
   assign pready     = stateReg.ready;
   assign pslverr    = stateReg.err;
   assign periodTick = stateReg.tick;
endmodule
`default_nettype wire

//--- rtl/tick_divider.sv
// Purpose: Prescale and postscale enable divider
// Assumes: Ratio is one more than the count limit given
// Notes:   Emits a single-cycle pulse every ratio qualified inputs
`default_nettype none
module tick_divider (
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic       clear,
   input  wire logic       tickIn,
   input  wire logic [5:0] limit,
   output logic            tickOut
);
   typedef struct packed {
      logic [5:0] cnt;
      logic       pulse;
   } div_state_type;

   div_state_type stateReg;
   div_state_type stateNext;

   always_comb begin
      stateNext       = stateReg;
      stateNext.pulse = 1'b0;
      if (clear) begin
         stateNext.cnt = 6'h00;
      end else if (tickIn) begin
         if (stateReg.cnt >= limit) begin
            stateNext.cnt   = 6'h00;
            stateNext.pulse = 1'b1;
         end else begin
            stateNext.cnt = stateReg.cnt + 6'h01;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         stateReg <= '0;
      end else begin
         stateReg <= stateNext;
      end
   end

   assign tickOut = stateNext.pulse;
endmodule
`default_nettype wire

//--- rtl/time_base_pkg.sv
// Purpose: Constants shared by the PWM time base counter block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Offsets of all registers are free choices of this block
`default_nettype none
package time_base_pkg;
   // -------------------------------------------------------------------
   // Register map
   // -------------------------------------------------------------------
   localparam logic [7:0]  CONTROL_ADDR     = 8'h00;
   localparam logic [7:0]  COUNT_ADDR       = 8'h04;
   localparam logic [7:0]  PERIOD_ADDR      = 8'h08;
   localparam logic [7:0]  IDLE_ADDR        = 8'h0C;
   // -------------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------------
   localparam int          ON_BIT           = 15;
   localparam int          IDLE_STOP_BIT    = 13;
   localparam int          POST_LSB         = 4;
   localparam int          PRE_LSB          = 2;
   localparam int          MODE_LSB         = 0;
   localparam int          DIR_BIT          = 15;
   localparam logic [15:0] CONTROL_MASK     = 16'hA0FF;
   localparam logic [15:0] COUNT_MASK       = 16'h7FFF;
   // -------------------------------------------------------------------
   // Reset values
   // -------------------------------------------------------------------
   localparam logic [15:0] CONTROL_RESET    = 16'h0000;
   localparam logic [14:0] COUNT_RESET      = 15'h0000;
   localparam logic [14:0] PERIOD_RESET     = 15'h0000;
   // -------------------------------------------------------------------
   // Modes
   // -------------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_FREE   = 2'b00,
      MODE_SINGLE = 2'b01,
      MODE_UPDOWN = 2'b10,
      MODE_UPDOWN_DBL = 2'b11
   } mode_type;
endpackage
`default_nettype wire

//--- verif/pwm_time_base_asserts.sv
// Purpose: Port assertions for the PWM time base counter
// Assumes: One wait state APB slave with registered outputs
// Notes:   Idle stop bit is shadowed from bus writes
`default_nettype none
module pwm_time_base_asserts
   import time_base_pkg::*;
(
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        idleMode,
   input wire logic        periodTick
);
   logic ctlWr;
   logic sidlReg;
   assign ctlWr = pready && pwrite && paddr == CONTROL_ADDR;
   // Hardware never alters the idle stop bit, so a shadow is exact
   always_ff @(posedge clk or negedge nrst)
      if (!nrst)
         sidlReg <= 1'b0;
      else if (ctlWr)
         sidlReg <= pwdata[IDLE_STOP_BIT];
   // ----
   // Assertions
   // ----
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held too long");
   chk_ready_wait: assert property (psel && penable && !pready |=> pready)
      else $error("ready late");
   chk_err_unmapped: assert property (pready && paddr[7:4] != 4'h0 |->
      pslverr) else $error("no error on unmapped address");
   chk_err_zero: assert property (pready && pslverr && !pwrite |->
      prdata == 32'h0) else $error("error read not zero");
   chk_upper_zero: assert property (pready && !pwrite |->
      prdata[31:16] == 16'h0) else $error("upper half not zero");
   chk_ctl_unused: assert property (pready && !pwrite &&
      paddr == CONTROL_ADDR |-> (prdata[15:0] & ~CONTROL_MASK) == 16'h0)
      else $error("unused control bit set");
   chk_tick_off: assert property (ctlWr && !pwdata[ON_BIT] |->
      ##3 !periodTick [*4]) else $error("tick while disabled");
   chk_idle_stop: assert property ((idleMode && sidlReg) [*5] |->
      !periodTick) else $error("tick while idle stopped");
endmodule
bind pwm_time_base_counter pwm_time_base_asserts chkr (.clk(clk),
   .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .idleMode(idleMode), .periodTick(periodTick));
`default_nettype wire

//--- verif/pwm_time_base_counter_test.sv
// Purpose: Self-checking bench for the PWM time base counter
// Assumes: One wait state APB slave, 20 MHz clock
// Notes:   Reads are queued and checked by a watcher process
`default_nettype none
module pwm_time_base_counter_test
   import time_base_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [32:0] ALL = 33'h1FFFFFFFF;
   logic        clk, nrst, psel, penable, pwrite, idleMode;
   logic        pready, pslverr, periodTick;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, lastRd;
   logic [32:0] expQ[$], mskQ[$];
   int          err_total, cmp_count, cyc, n, p, s;
   always #25 clk = ~clk;
   pwm_time_base_counter dut (.clk(clk), .nrst(nrst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .idleMode(idleMode), .periodTick(periodTick));
   // ----
   // Bus and check tasks
   // ----
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int k;
      k = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && k < 20) begin
         k++;
         @(posedge clk);
      end
      if (k == 20) begin
         err_total++;
         $display("Error %0t no ready from slave", $time);
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [32:0] e, m);
      expQ.push_back(e);
      mskQ.push_back(m);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic chk(input logic ok);
      cmp_count++;
      if (ok !== 1'b1) begin
         err_total++;
         $display("Error %0t tick or direction", $time);
      end
   endtask
   task automatic give_verdict();
      $display("Compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Bit 32 of a note is the error response
   always @(posedge clk) begin
      cyc++;
      if (pready === 1'b1 && pwrite === 1'b0 && expQ.size() > 0) begin
         lastRd = prdata;
         cmp_count++;
         if (({pslverr, prdata} & mskQ[0]) !== (expQ[0] & mskQ[0])) begin
            err_total++;
            $display("Error %0t read %h", $time, {pslverr, prdata});
         end
         void'(expQ.pop_front());
         void'(mskQ.pop_front());
      end
      if (cyc == 60000) begin
         err_total++;
         give_verdict();
      end
   end
   initial begin
      {clk, nrst, psel, penable, pwrite, idleMode} = 6'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      void'($urandom(67387));
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      rd(CONTROL_ADDR, 33'h0, ALL);
      rd(COUNT_ADDR, 33'h0, ALL);
      rd(8'h40, 33'h100000000, ALL);
      for (int i = 0; i < 4; i++) begin
         s = $urandom() & 32'h7FFF;
         s[1:0] = i[1:0];
         apb(1'b1, CONTROL_ADDR, s);
         rd(CONTROL_ADDR, 33'(s & CONTROL_MASK), ALL);
         p = (i == 0) ? -1 : $urandom();
         apb(1'b1, COUNT_ADDR, p);
         rd(COUNT_ADDR, 33'(p & COUNT_MASK), ALL);
      end
      // Each prescale code with random period and postscale
      for (int i = 0; i < 4; i++) begin
         p = 3 + $urandom() % 4;
         s = $urandom() % 3;
         apb(1'b1, PERIOD_ADDR, p);
         apb(1'b1, CONTROL_ADDR, 32'h8000 | s << 4 | i << 2);
         for (int t = 0; t < 2; t++) begin
            n = 0;
            do begin
               @(posedge clk);
               n++;
            end while (periodTick !== 1'b1 && n < 9000);
         end
         chk(n == (((p + 1) * (s + 1)) << (2 * i)));
      end
      idleMode <= 1'b1;
      for (int i = 0; i < 2; i++) begin
         apb(1'b1, CONTROL_ADDR, 32'h8000 | i << 13);
         repeat (8) @(posedge clk);
         n = 0;
         repeat (200) @(posedge clk) n += int'(periodTick === 1'b1);
         chk((n == 0) == (i == 1));
      end
      idleMode <= 1'b0;
      apb(1'b1, CONTROL_ADDR, 32'h0);
      apb(1'b1, CONTROL_ADDR, 32'h8001);
      repeat (30) @(posedge clk);
      rd(CONTROL_ADDR, 33'h1, ALL);
      apb(1'b1, PERIOD_ADDR, 32'h5);
      apb(1'b1, CONTROL_ADDR, 32'h8002);
      n = 0;
      lastRd = 32'h0;
      while (lastRd[15] !== 1'b1 && n < 30) begin
         rd(COUNT_ADDR, 33'h0, 33'h0);
         n++;
      end
      chk(lastRd[15] === 1'b1 && lastRd[14:0] <= 15'h5);
      // Up/down with ticks at both ends: two ticks per full sweep
      apb(1'b1, CONTROL_ADDR, 32'h8003);
      for (int t = 0; t < 3; t++) begin
         if (t == 1)
            n = 0;
         do begin
            @(posedge clk);
            n++;
         end while (periodTick !== 1'b1 && n < 9000);
         if (t == 0)
            n = 0;
      end
      chk(n == 10);
      give_verdict();
   end
endmodule
`default_nettype wire
